// [hw/vlink_regs_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and carriers for the virtual link register slice
// Assumes: 32-bit classic wishbone, word index = byte address / 4
// Notes:   printed offsets are kept as word indices, byte address is 4x
//////////////////////////////////////////////////////////////////////////////
package vlink_regs_pkg;

  // word index width decoded from the bus address
  localparam int unsigned IDX_W = 10;

  // register word indices
  localparam logic [9:0] IDX_DEV_STATUS = 10'h04A;
  localparam logic [9:0] IDX_LINK_CAP = 10'h04C;
  localparam logic [9:0] IDX_LINK_CTL = 10'h050;
  localparam logic [9:0] IDX_LINK_STS = 10'h052;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h060;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h061;

  // hardwired link codes
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [5:0] LANES_X8 = 6'h08;
  localparam logic [1:0] PM_L0S_ONLY = 2'h1;
  localparam logic [2:0] L0S_LAT_LT64NS = 3'h0;
  localparam logic [2:0] L1_LAT_LT1US = 3'h0;
  localparam logic [7:0] PORT_ZERO = 8'h00;

  // field positions in the link control word
  localparam int unsigned CTL_PM_LSB = 0;
  localparam int unsigned CTL_SHARED_CLK = 6;
  localparam int unsigned CTL_LONG_SYNC = 7;

  // reset values
  localparam logic [1:0] PM_CTL_RST = 2'h0;
  localparam logic [3:0] ERR_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // error events, also the layout of device status bits 3:0 and irq bits
  typedef struct packed {
    logic ur;
    logic fatal;
    logic nonfatal;
    logic corr;
  } err_evt_t;

  typedef struct packed {
    logic [7:0] port_index;
    logic [5:0] rsvd;
    logic [2:0] l1_wake_latency;
    logic [2:0] l0s_wake_latency;
    logic [1:0] power_state_support;
    logic [5:0] top_lane_count;
    logic [3:0] top_speed_code;
  } link_cap_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic slot_clock;
    logic train_active;
    logic train_fault;
    logic [5:0] negotiated_lanes;
    logic [3:0] current_speed;
  } link_sts_t;

endpackage : vlink_regs_pkg

// [hw/vlink_regs.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: config register slice of a virtual link endpoint
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes:   one wait state on every access, unmapped words read zero
//////////////////////////////////////////////////////////////////////////////
// Function
// R1 - set unsupported-request flag on receipt; writing one clears it
// R2 - log unsupported-request flag regardless of its reporting enable
// R3 - auxiliary power detected bit always reads zero
// R4 - transactions pending bit always reads zero
// R5 - maximum link speed field reads 0x1, meaning 2.5 Gbps
// R6 - maximum link width field reads 0x8
// R7 - power management support field reads 0x01, L0s entry only
// R8 - L0s exit latency field reads zero, below 64ns
// R9 - L1 exit latency field reads zero, below 1us
// R10 - port number field reads zero
// R11 - power management control field is read-write, resets to zero
// R12 - read completion boundary, disable and retrain bits read zero
// R13 - shared clock and long sync bits are plain storage, reset zero
// R14 - current link speed field reads 0x1
// R15 - negotiated link width field reads 0x8
// R16 - training error, training and slot clock bits read zero
// R17 - writes to reserved or read-only fields ignored; reserved reads zero
// R18 - correctable, non-fatal, fatal flags are W1C and always logged
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps

module vlink_regs #(
  parameter int unsigned ADR_W = 12,
  parameter logic [5:0] LANE_COUNT = vlink_regs_pkg::LANES_X8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire vlink_regs_pkg::err_evt_t err_evt_i,
  input wire logic ur_report_en_i,
  output logic [1:0] pm_ctl_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [9:0] idx;
  logic req;
  logic take;
  logic wr_take;
  logic rd_take;
  logic hit_dsts;
  logic hit_lcap;
  logic hit_lctl;
  logic hit_lsts;
  logic hit_isr;
  logic hit_imr;
  logic wr_lane0;

  assign idx = adr_i[vlink_regs_pkg::IDX_W+1:2];
  assign req = cyc_i & stb_i;
  // a request is taken once; ack high blocks a second take
  assign take = req & ~ack_o;
  assign wr_take = take & we_i;
  assign rd_take = take & ~we_i;
  assign wr_lane0 = wr_take & sel_i[0];
  assign hit_dsts = idx == vlink_regs_pkg::IDX_DEV_STATUS;
  assign hit_lcap = idx == vlink_regs_pkg::IDX_LINK_CAP;
  assign hit_lctl = idx == vlink_regs_pkg::IDX_LINK_CTL;
  assign hit_lsts = idx == vlink_regs_pkg::IDX_LINK_STS;
  assign hit_isr = idx == vlink_regs_pkg::IDX_IRQ_STATUS;
  assign hit_imr = idx == vlink_regs_pkg::IDX_IRQ_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [3:0] err_r;
  logic [3:0] err_nxt;
  logic [3:0] err_clr;
  logic [3:0] evt_vec;
  logic [3:0] isr_r;
  logic [3:0] isr_nxt;
  logic [3:0] imr_r;
  logic [1:0] pm_ctl_r;
  logic shared_clock_cfg_r;
  logic long_sync_r;

  // the reporting enable only gates messages elsewhere, never logging
  assign evt_vec = err_evt_i; // see R2

  // hardware set wins over a same-cycle write-one clear
  assign err_clr = (wr_lane0 & hit_dsts) ? dat_i[3:0] : 4'h0; // see R1
  assign err_nxt = (err_r & ~err_clr) | evt_vec; // see R18

  // read of the irq status clears it, but a new event still lands
  assign isr_nxt = ((rd_take & hit_isr) ? 4'h0 : isr_r) | evt_vec;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r <= vlink_regs_pkg::ERR_RST;
      isr_r <= vlink_regs_pkg::ERR_RST;
    end else begin
      err_r <= err_nxt; // see R1
      isr_r <= isr_nxt;
    end
  end

  // link control: only bits 1:0, 6 and 7 hold anything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_ctl_r <= vlink_regs_pkg::PM_CTL_RST; // see R11
      shared_clock_cfg_r <= 1'b0; // see R13
      long_sync_r <= 1'b0; // see R13
    end else if (wr_lane0 & hit_lctl) begin
      pm_ctl_r <= dat_i[vlink_regs_pkg::CTL_PM_LSB +: 2]; // see R11
      shared_clock_cfg_r <= dat_i[vlink_regs_pkg::CTL_SHARED_CLK]; // see R13
      long_sync_r <= dat_i[vlink_regs_pkg::CTL_LONG_SYNC]; // see R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imr_r <= vlink_regs_pkg::MASK_RST;
    end else if (wr_lane0 & hit_imr) begin
      imr_r <= dat_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed words

  vlink_regs_pkg::link_cap_t link_cap;
  vlink_regs_pkg::link_sts_t link_sts;

  always_comb begin
    link_cap = '0; // see R17
    link_cap.top_speed_code = vlink_regs_pkg::SPEED_2G5; // see R5
    link_cap.top_lane_count = LANE_COUNT; // see R6
    // advertised only; the virtual link never changes power state
    link_cap.power_state_support = vlink_regs_pkg::PM_L0S_ONLY; // see R7
    link_cap.l0s_wake_latency = vlink_regs_pkg::L0S_LAT_LT64NS; // see R8
    link_cap.l1_wake_latency = vlink_regs_pkg::L1_LAT_LT1US; // see R9
    link_cap.port_index = vlink_regs_pkg::PORT_ZERO; // see R10
  end

  always_comb begin
    link_sts = '0; // see R16
    link_sts.current_speed = vlink_regs_pkg::SPEED_2G5; // see R14
    link_sts.negotiated_lanes = LANE_COUNT; // see R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [15:0] dsts_word;
  logic [15:0] lctl_word;
  logic [31:0] rd_word;

  // aux power seen and pending non-posted stay zero above the flags
  assign dsts_word = {12'h000, err_r}; // see R3 see R4
  // completion boundary, lane disable and lane retrain never stored
  assign lctl_word = {8'h00, long_sync_r, shared_clock_cfg_r,
                      3'h0, 1'b0, pm_ctl_r}; // see R12

  always_comb begin
    rd_word = 32'h0000_0000; // see R17
    if (hit_dsts) begin
      rd_word = {16'h0000, dsts_word};
    end else if (hit_lcap) begin
      rd_word = link_cap;
    end else if (hit_lctl) begin
      rd_word = {16'h0000, lctl_word};
    end else if (hit_lsts) begin
      rd_word = {16'h0000, link_sts};
    end else if (hit_isr) begin
      rd_word = {28'h000_0000, isr_r};
    end else if (hit_imr) begin
      rd_word = {28'h000_0000, imr_r};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= take;
      if (rd_take) begin
        dat_o <= rd_word;
      end
    end
  end

  assign pm_ctl_o = pm_ctl_r;
  assign irq_o = |(isr_r & imr_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic rd_ack;
  assign rd_ack = ack_o & ~we_i;

  a_ur_flag_set: assert property ( // see R1
    @(posedge clk_i) disable iff (rst_i)
    err_evt_i.ur |=> err_r[3])
    else $error("unsupported request not logged");

  a_ur_flag_clear: assert property ( // see R1
    @(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit_dsts && dat_i[3] && !err_evt_i.ur |=> !err_r[3])
    else $error("write one did not clear unsupported request flag");

  a_ur_no_enable: assert property ( // see R2
    @(posedge clk_i) disable iff (rst_i)
    err_evt_i.ur && !ur_report_en_i |=> dsts_word[3])
    else $error("unsupported request lost with reporting disabled");

  a_dsts_hardwired: assert property ( // see R3
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_dsts |-> dat_o[31:4] == 28'h000_0000)
    else $error("aux power or pending bit read nonzero");

  a_pending_zero: assert property ( // see R4
    @(posedge clk_i) disable iff (rst_i)
    rd_take && hit_dsts |=> !dat_o[5])
    else $error("pending non-posted bit set");

  a_cap_word: assert property ( // see R5
    @(posedge clk_i) disable iff (rst_i)
    rd_take && hit_lcap |=> ack_o && dat_o == 32'h0000_0481)
    else $error("link capabilities word wrong");

  a_cap_fields: assert property ( // see R7
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_lcap |-> dat_o[11:10] == 2'h1 && dat_o[9:4] == 6'h08
      && dat_o[3:0] == 4'h1)
    else $error("speed, width or power support field wrong");

  a_cap_latency: assert property ( // see R8
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_lcap |-> dat_o[17:12] == 6'h00 && dat_o[31:18] == 14'h0)
    else $error("latency, reserved or port field nonzero");

  a_pm_ctl_rw: assert property ( // see R11
    @(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit_lctl |=> pm_ctl_o == $past(dat_i[1:0]))
    else $error("power control field did not take write");

  a_ctl_readback: assert property ( // see R12
    @(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit_lctl ##1 ack_o ##1 !ack_o ##1 rd_take && hit_lctl
    |=> dat_o[5:2] == 4'h0 && dat_o[7:6] == $past(dat_i[7:6], 4))
    else $error("link control readback wrong");

  a_ctl_store: assert property ( // see R13
    @(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit_lctl |=> {long_sync_r, shared_clock_cfg_r}
      == $past(dat_i[7:6]))
    else $error("shared clock or long sync not stored");

  a_sts_word: assert property ( // see R14
    @(posedge clk_i) disable iff (rst_i)
    rd_take && hit_lsts |=> dat_o == 32'h0000_0081)
    else $error("link status word wrong");

  a_unmapped_zero: assert property ( // see R17
    @(posedge clk_i) disable iff (rst_i)
    rd_take && !(hit_dsts || hit_lcap || hit_lctl || hit_lsts || hit_isr
      || hit_imr) |=> dat_o == 32'h0000_0000)
    else $error("unmapped word read nonzero");

  a_err_logged: assert property ( // see R18
    @(posedge clk_i) disable iff (rst_i)
    |err_evt_i[2:0] |=> (err_r[2:0] & $past(evt_vec[2:0]))
      == $past(evt_vec[2:0]))
    else $error("error event not logged");

  a_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle pulse");

  // read-only fields, field by field, so a failure names the rule

  a_aux_zero: assert property ( // see R3
    @(posedge clk_i) disable iff (rst_i)
    rd_take && hit_dsts |=> !dat_o[4])
    else $error("aux power seen bit set");

  a_lane_cap: assert property ( // see R6
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_lcap |-> dat_o[9:4] == vlink_regs_pkg::LANES_X8)
    else $error("maximum lane count field wrong");

  a_l1_latency: assert property ( // see R9
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_lcap |-> dat_o[17:15] == vlink_regs_pkg::L1_LAT_LT1US)
    else $error("l1 wake latency field wrong");

  a_port_zero: assert property ( // see R10
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_lcap |-> dat_o[31:24] == vlink_regs_pkg::PORT_ZERO)
    else $error("port index field nonzero");

  a_ctl_ro_zero: assert property ( // see R12
    @(posedge clk_i) disable iff (rst_i)
    rd_take && hit_lctl |=> dat_o[5:2] == 4'h0 && dat_o[31:8] == 24'h0)
    else $error("read-only link control bits nonzero");

  a_sts_lanes: assert property ( // see R15
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_lsts |-> dat_o[9:4] == vlink_regs_pkg::LANES_X8)
    else $error("negotiated lane field wrong");

  a_sts_ro_bits: assert property ( // see R16
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_lsts |-> dat_o[31:10] == 22'h0)
    else $error("training or slot clock bit set");

  ////////////////////////////////////////////////////////////////////////////
  // writable state

  // no disable here: the edge that sees reset low must find it applied
  a_reset_state: assert property ( // see R11
    @(posedge clk_i)
    $fell(rst_i) |-> pm_ctl_o == vlink_regs_pkg::PM_CTL_RST
      && !shared_clock_cfg_r && !long_sync_r && err_r == 4'h0 && !ack_o)
    else $error("state not cleared by reset");

  a_mask_rw: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit_imr |=> imr_r == $past(dat_i[3:0]))
    else $error("irq mask did not take write");

  a_no_lane0_write: assert property ( // see R17
    @(posedge clk_i) disable iff (rst_i)
    wr_take && !sel_i[0] |=> $stable(pm_ctl_o) && $stable(imr_r))
    else $error("write without byte enable changed state");

  a_w1c_all: assert property ( // see R18
    @(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit_dsts && dat_i[2:0] == 3'h7 && evt_vec[2:0] == 3'h0
    |=> err_r[2:0] == 3'h0)
    else $error("write one left an error flag set");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and bus protocol

  a_irq_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (evt_vec & imr_r) != 4'h0 && !(wr_lane0 && hit_imr) |=> irq_o)
    else $error("unmasked event did not raise irq");

  // the read returns the old bits; only a same-cycle event survives
  a_isr_read_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_take && hit_isr |=> isr_r == $past(evt_vec))
    else $error("irq status not cleared by read");

  a_ack_after_take: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |-> $past(take))
    else $error("ack without a taken request");

  a_rd_data_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rd_take |=> $stable(dat_o))
    else $error("read data changed without a read");

  a_idle_no_ack: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack raised with no request");

endmodule : vlink_regs

// [tb/vlink_regs_tb.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the virtual link register slice
// Assumes: one wait state per access, status read clears irq flags
// Notes:   bus driven on rising edges; irq sampled on falling edges after event pulses, on rising edges after reads
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module vlink_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  vlink_regs_pkg::err_evt_t err_evt_i = '0;
  logic ur_report_en_i = 1'b0;
  logic [1:0] pm_ctl_o;
  logic irq_o;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] q;
  logic [31:0] d;
  logic [3:0] ev;
  logic [3:0] acc;
  logic [3:0] msk;
  logic [3:0] clr;

  vlink_regs #(.ADR_W(12)) i_vlink_regs (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_evt_i(err_evt_i),
    .ur_report_en_i(ur_report_en_i), .pm_ctl_o(pm_ctl_o), .irq_o(irq_o)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // one classic cycle; bounded wait so a dead slave cannot hang the run
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] wd, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= wd;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        $display("BAD %0t no ack", $time);
        errors++;
        summarize();
      end
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [11:0] a);
    wb(1'b0, a, 32'h00000000, 4'h0);
  endtask : rd

  task automatic pulse(input logic [3:0] e);
    @(posedge clk_i);
    err_evt_i <= vlink_regs_pkg::err_evt_t'(e);
    @(posedge clk_i);
    err_evt_i <= '0;
    @(negedge clk_i);
  endtask : pulse

  function automatic logic [31:0] ctl_exp(input logic [31:0] w);
    return {24'h000000, w[7:6], 4'h0, w[1:0]};
  endfunction : ctl_exp

  //////////////////////////////////////////////////////////////////////////
  initial begin
    q = $urandom(21376);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h130);
    check(q, 32'h00000481, "link cap");
    rd(12'h148);
    check(q, 32'h00000081, "link sts");
    rd(12'h140);
    check(q, 32'h00000000, "link ctl reset");
    rd(12'h128);
    check(q, 32'h00000000, "dev sts reset");
    check({30'h0, pm_ctl_o}, 32'h00000000, "pm reset");
    $display("test reset values done");
    // writes of all ones (device status flag bits zero) to fixed and unmapped words must leave them unchanged
    wb(1'b1, 12'h130, 32'hFFFFFFFF, 4'hF);
    wb(1'b1, 12'h148, 32'hFFFFFFFF, 4'hF);
    wb(1'b1, 12'h128, 32'hFFFFFFF0, 4'hF);
    wb(1'b1, 12'h3FC, 32'hFFFFFFFF, 4'hF);
    rd(12'h130);
    check(q, 32'h00000481, "link cap ro");
    rd(12'h148);
    check(q, 32'h00000081, "link sts ro");
    rd(12'h128);
    check(q, 32'h00000000, "dev sts ro");
    rd(12'h3FC);
    check(q, 32'h00000000, "unmapped");
    $display("test read-only done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $urandom();
      wb(1'b1, 12'h140, d, 4'h1);
      rd(12'h140);
      check(q, ctl_exp(d), "link ctl");
      check({30'h0, pm_ctl_o}, {30'h0, d[1:0]}, "pm out");
    end
    wb(1'b1, 12'h140, 32'h00000000, 4'h0);
    rd(12'h140);
    check(q, ctl_exp(d), "ctl no byte enable");
    $display("test link control done");
    acc = 4'h0;
    for (int i = 0; i < 10; i++) begin
      ev = 4'($urandom());
      msk = 4'($urandom());
      clr = 4'($urandom());
      if (i == 0) begin
        ev = 4'h8;
        msk = 4'h8;
      end
      if (i == 1) begin
        ev = 4'hF;
        msk = 4'h0;
      end
      ur_report_en_i <= i[0];
      wb(1'b1, 12'h184, {28'h0, msk}, 4'h1);
      rd(12'h184);
      check(q, {28'h0, msk}, "irq mask");
      pulse(ev);
      check({31'h0, irq_o}, {31'h0, |(ev & msk)}, "irq level");
      acc = acc | ev;
      rd(12'h128);
      check(q, {28'h0, acc}, "dev sts set");
      wb(1'b1, 12'h128, {28'h0, clr}, 4'h1);
      acc = acc & ~clr;
      rd(12'h128);
      check(q, {28'h0, acc}, "dev sts w1c");
      rd(12'h180);
      check(q, {28'h0, ev}, "irq status");
      rd(12'h180);
      check(q, 32'h00000000, "irq read clear");
      check({31'h0, irq_o}, 32'h00000000, "irq cleared");
    end
    $display("test events done");
    // an event in the cycle of a clear must survive it
    fork
      wb(1'b1, 12'h128, 32'h0000000F, 4'h1);
      pulse(4'h8);
    join
    rd(12'h128);
    check(q, 32'h00000008, "set beats w1c");
    fork
      rd(12'h180);
      pulse(4'h1);
    join
    check(q, 32'h00000008, "irq read old value");
    rd(12'h180);
    check(q, 32'h00000001, "set beats read clear");
    $display("test clear races done");
    // reset in mid-run must drop the stored control bits and flags
    wb(1'b1, 12'h140, 32'h000000C3, 4'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h140);
    check(q, 32'h00000000, "ctl after reset");
    check({30'h0, pm_ctl_o}, 32'h00000000, "pm after reset");
    rd(12'h128);
    check(q, 32'h00000000, "flags after reset");
    rd(12'h180);
    check(q, 32'h00000000, "irq status after reset");
    rd(12'h184);
    check(q, 32'h00000000, "irq mask after reset");
    check({31'h0, irq_o}, 32'h00000000, "irq after reset");
    $display("test second reset done");
    summarize();
  end
endmodule : vlink_regs_tb
